// ==== verilog/adcms_ctrl.sv ====
// Operating-mode, conversion sequencing and serial command front end of the converter.
module adcms_ctrl #(
  parameter int MOD_CLKS = adcms_pkg::MOD_PERIOD_CLKS,
  parameter int CONV_MODS = adcms_pkg::CONV_MODS_DEFAULT
) (
  // Master clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Serial port pins.
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  output logic serial_out_ready,
  output logic serial_out_ready_oe_n,
  // Conversion trigger pin.
  input wire logic conversion_trigger_pin,
  // Status and analog controls.
  output logic result_ready_n,
  output logic [1:0] op_state,
  output logic filter_reset,
  output logic core_clk_enable,
  output logic amp_enable,
  output logic ref_enable,
  output logic excitation_enable,
  output logic conv_active,
  // Calibration request towards the arithmetic.
  output logic cal_valid,
  output logic [1:0] cal_kind
);

  // =====================================================================
  // Serial clock domain.
  // Chip select high holds the shifter and byte framing in reset, so a broken frame
  // can never leave a half-shifted byte behind.
  wire spi_rst_n = rst_n & ~cs_n;

  logic [2:0] bit_cnt;
  logic [6:0] shreg;
  adcms_pkg::adcms_phase_t phase;
  logic [4:0] wr_left;
  logic [4:0] wr_ptr;
  logic [4:0] wr_addr_s;
  logic [7:0] wr_data_s;
  logic wr_tog;
  adcms_pkg::adcms_cmd_t cmd_s;
  logic cmd_tog;

  wire [7:0] rx_byte = {shreg, din};
  wire [6:0] rx_op7 = {shreg[5:0], din};
  wire seventh_edge = (bit_cnt == 3'h6);
  wire byte_done = (bit_cnt == 3'h7);
  wire in_cmd = (phase == adcms_pkg::PH_CMD);

  // Control opcodes take effect on the seventh edge, lowest bit ignored.
  wire ctl_hit = in_cmd && seventh_edge && (rx_op7 >= adcms_pkg::OP7_WAKE)
                 && (rx_op7 <= adcms_pkg::OP7_STOP);
  wire cal_hit = in_cmd && byte_done && ((rx_byte == adcms_pkg::OP_SYO_CAL)
                 || (rx_byte == adcms_pkg::OP_SYG_CAL) || (rx_byte == adcms_pkg::OP_SFO_CAL));

  function automatic adcms_pkg::adcms_cmd_t ctl_code(input logic [6:0] op);
    unique case (op)
      adcms_pkg::OP7_WAKE: ctl_code = adcms_pkg::CMD_WAKE;
      adcms_pkg::OP7_SLEEP: ctl_code = adcms_pkg::CMD_SLEEP;
      adcms_pkg::OP7_RESET: ctl_code = adcms_pkg::CMD_RESET;
      adcms_pkg::OP7_START: ctl_code = adcms_pkg::CMD_START;
      default: ctl_code = adcms_pkg::CMD_STOP;
    endcase
  endfunction

  function automatic adcms_pkg::adcms_cmd_t cal_code(input logic [7:0] op);
    unique case (op)
      adcms_pkg::OP_SYO_CAL: cal_code = adcms_pkg::CMD_SYO_CAL;
      adcms_pkg::OP_SYG_CAL: cal_code = adcms_pkg::CMD_SYG_CAL;
      default: cal_code = adcms_pkg::CMD_SFO_CAL;
    endcase
  endfunction

  // Bits are captured on the falling edge of the serial clock only.
  always_ff @(negedge sclk or negedge spi_rst_n) begin
    if (!spi_rst_n) begin
      bit_cnt <= 3'h0;
      shreg <= 7'h00;
    end else begin
      bit_cnt <= bit_cnt + 3'h1;
      shreg <= {shreg[5:0], din};
    end
  end

  // Command publication: code stays stable while its toggle crosses over.
  always_ff @(negedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_s <= adcms_pkg::CMD_STOP;
      cmd_tog <= 1'b0;
    end else if (ctl_hit) begin
      cmd_s <= ctl_code(rx_op7);
      cmd_tog <= ~cmd_tog;
    end else if (cal_hit) begin
      cmd_s <= cal_code(rx_byte);
      cmd_tog <= ~cmd_tog;
    end
  end

  // Byte framing: register commands own the bytes that follow them, so
  // their count and data bytes are never taken as commands.
  always_ff @(negedge sclk or negedge spi_rst_n) begin
    if (!spi_rst_n) begin
      phase <= adcms_pkg::PH_CMD;
      wr_left <= 5'h00;
      wr_ptr <= 5'h00;
    end else if (byte_done) begin
      unique case (phase)
        adcms_pkg::PH_CMD: begin
          wr_ptr <= rx_byte[4:0];
          if (rx_byte[7:5] == adcms_pkg::OP_REGISTER_WRITE_CMD_HI) begin
            phase <= adcms_pkg::PH_WCNT;
          end else if (rx_byte[7:5] == adcms_pkg::OP_REGISTER_READ_CMD_HI) begin
            phase <= adcms_pkg::PH_RCNT;
          end
        end
        adcms_pkg::PH_WCNT: begin
          wr_left <= rx_byte[4:0];
          phase <= adcms_pkg::PH_WDATA;
        end
        adcms_pkg::PH_WDATA: begin
          wr_ptr <= wr_ptr + 5'h01;
          wr_left <= wr_left - 5'h01;
          if (wr_left == 5'h00) begin
            phase <= adcms_pkg::PH_CMD;
          end
        end
        adcms_pkg::PH_RCNT: phase <= adcms_pkg::PH_CMD;
      endcase
    end
  end

  // Each written byte is published with its address and a toggle.
  always_ff @(negedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      wr_addr_s <= 5'h00;
      wr_data_s <= 8'h00;
      wr_tog <= 1'b0;
    end else if (byte_done && phase == adcms_pkg::PH_WDATA) begin
      wr_addr_s <= wr_ptr;
      wr_data_s <= rx_byte;
      wr_tog <= ~wr_tog;
    end
  end

  // =====================================================================
  // Crossings into the master clock domain.
  // The toggles sit outside the chip-select reset, since clearing them on
  // deselect would look like one more command or write on this side.
  logic [2:0] cmd_sync;
  logic [2:0] wr_sync;
  logic [2:0] trig_sync;
  logic [1:0] cs_sync;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_sync <= 3'h0;
      wr_sync <= 3'h0;
      trig_sync <= 3'h0;
      cs_sync <= 2'h3;
    end else begin
      cmd_sync <= {cmd_sync[1:0], cmd_tog};
      wr_sync <= {wr_sync[1:0], wr_tog};
      trig_sync <= {trig_sync[1:0], conversion_trigger_pin};
      cs_sync <= {cs_sync[0], cs_n};
    end
  end

  wire cmd_evt = cmd_sync[2] ^ cmd_sync[1];
  wire wr_evt = wr_sync[2] ^ wr_sync[1];
  wire trig_rise = trig_sync[1] & ~trig_sync[2];
  wire trig_fall = trig_sync[2] & ~trig_sync[1];
  wire is_cmd_wake = cmd_evt && (cmd_s == adcms_pkg::CMD_WAKE);
  wire is_cmd_sleep = cmd_evt && (cmd_s == adcms_pkg::CMD_SLEEP);
  wire is_cmd_reset = cmd_evt && (cmd_s == adcms_pkg::CMD_RESET);
  wire is_cmd_start = cmd_evt && (cmd_s == adcms_pkg::CMD_START);
  wire is_cmd_stop = cmd_evt && (cmd_s == adcms_pkg::CMD_STOP);
  wire is_cmd_cal = cmd_evt && (cmd_s >= adcms_pkg::CMD_SYO_CAL);

  // =====================================================================
  // Configuration registers and mode state.
  adcms_pkg::adcms_state_t state;
  logic [7:0] reg_gain;
  logic [7:0] reg_rate;
  logic [7:0] reg_ref;
  logic [19:0] timer;
  logic [1:0] shots_left;
  logic stop_pending;

  wire in_pd = (state == adcms_pkg::ST_SLEEP_CMD);
  wire converting = (state == adcms_pkg::ST_SETTLE) || (state == adcms_pkg::ST_CONVERT);
  wire single_mode = reg_rate[adcms_pkg::MODE_BIT];
  wire low_latency = reg_rate[adcms_pkg::FILTER_BIT];
  wire wr_ok = wr_evt && !in_pd;
  wire wr_settle_addr = (wr_addr_s >= adcms_pkg::ADDR_GAIN)
                        && (wr_addr_s <= adcms_pkg::ADDR_SETTLE_LAST);
  wire soft_reset = is_cmd_reset && !in_pd;
  // A start, a pin rising edge or a settling write during conversion all
  // restart with the settling delay; the running conversion is dropped.
  wire start_evt = !in_pd && (is_cmd_start || trig_rise
                   || (wr_ok && wr_settle_addr && converting));
  wire stop_evt = is_cmd_stop || trig_fall;
  wire last_tick = (timer == 20'h00000);

  // Delay code to modulator periods; code zero is the reset setting.
  function automatic logic [12:0] settle_mods(input logic [2:0] code);
    unique case (code)
      3'h0: settle_mods = 13'h000e;
      3'h1: settle_mods = 13'h0019;
      3'h2: settle_mods = 13'h0040;
      3'h3: settle_mods = 13'h0100;
      3'h4: settle_mods = 13'h0400;
      3'h5: settle_mods = 13'h0800;
      3'h6: settle_mods = 13'h1000;
      default: settle_mods = 13'h0001;
    endcase
  endfunction

  wire [2:0] settle_code = reg_gain[adcms_pkg::SETTLE_MSB:adcms_pkg::SETTLE_LSB];
  wire [19:0] settle_load = 20'(settle_mods(settle_code) * MOD_CLKS - 1);
  wire [19:0] conv_load = 20'(CONV_MODS * MOD_CLKS - 1);
  // Sinc3 single-shot keeps only its third result.
  wire [1:0] shots_load = (single_mode && !low_latency) ? adcms_pkg::SINC3_SHOTS
                          : 2'h1;
  wire deliver = (state == adcms_pkg::ST_CONVERT) && last_tick && (shots_left == 2'h1);
  wire discard = (state == adcms_pkg::ST_CONVERT) && last_tick && (shots_left != 2'h1);

  // Register file; writes are dropped while powered down.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_gain <= adcms_pkg::GAIN_RESET;
      reg_rate <= adcms_pkg::RATE_RESET;
      reg_ref <= adcms_pkg::REF_RESET;
    end else if (soft_reset) begin
      reg_gain <= adcms_pkg::GAIN_RESET;
      reg_rate <= adcms_pkg::RATE_RESET;
      reg_ref <= adcms_pkg::REF_RESET;
    end else if (wr_ok) begin
      if (wr_addr_s == adcms_pkg::ADDR_GAIN) reg_gain <= wr_data_s;
      if (wr_addr_s == adcms_pkg::ADDR_RATE) reg_rate <= wr_data_s;
      if (wr_addr_s == adcms_pkg::ADDR_REF) reg_ref <= wr_data_s;
    end
  end

  // Mode sequencer; priority is reset, sleep, wake, start, then timing.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= adcms_pkg::ST_STANDBY;
      timer <= 20'h00000;
      shots_left <= 2'h1;
      stop_pending <= 1'b0;
      result_ready_n <= 1'b1;
    end else if (soft_reset) begin
      state <= adcms_pkg::ST_STANDBY;
      stop_pending <= 1'b0;
      result_ready_n <= 1'b1;
    end else if (is_cmd_sleep) begin
      state <= adcms_pkg::ST_SLEEP_CMD;
      stop_pending <= 1'b0;
    end else if (is_cmd_wake && in_pd) begin
      state <= adcms_pkg::ST_STANDBY;
    end else if (start_evt) begin
      state <= adcms_pkg::ST_SETTLE;
      timer <= settle_load;
      shots_left <= shots_load;
      stop_pending <= 1'b0;
      result_ready_n <= 1'b1;
    end else if (converting) begin
      if (stop_evt && !single_mode) stop_pending <= 1'b1;
      if (!last_tick) begin
        timer <= timer - 20'h00001;
      end else if (state == adcms_pkg::ST_SETTLE || discard) begin
        state <= adcms_pkg::ST_CONVERT;
        timer <= conv_load;
        if (discard) shots_left <= shots_left - 2'h1;
      end else begin
        result_ready_n <= 1'b0;
        timer <= conv_load;
        shots_left <= shots_load;
        if (single_mode || stop_pending || (stop_evt && !single_mode)) begin
          state <= adcms_pkg::ST_STANDBY;
          stop_pending <= 1'b0;
        end
      end
    end
  end

  // =====================================================================
  // Registered outputs.
  // The reference may stay on through power-down when software leaves it
  // enabled, trading power for a faster restart; excitation never does.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      op_state <= 2'h1;
      filter_reset <= 1'b1;
      core_clk_enable <= 1'b0;
      amp_enable <= 1'b0;
      ref_enable <= 1'b0;
      excitation_enable <= 1'b0;
      conv_active <= 1'b0;
      serial_out_ready <= 1'b1;
      serial_out_ready_oe_n <= 1'b1;
    end else begin
      op_state <= state;
      filter_reset <= !converting;
      core_clk_enable <= converting;
      amp_enable <= (reg_gain[adcms_pkg::AMP_MSB:adcms_pkg::AMP_LSB] != 2'h0)
                    && !in_pd;
      ref_enable <= (reg_ref[adcms_pkg::REFPWR_MSB:adcms_pkg::REFPWR_LSB] != 2'h0);
      excitation_enable <= (reg_ref[adcms_pkg::REFPWR_MSB:adcms_pkg::REFPWR_LSB] != 2'h0)
                           && !in_pd;
      conv_active <= converting;
      serial_out_ready <= result_ready_n;
      serial_out_ready_oe_n <= cs_sync[1];
    end
  end

  // Calibration requests pass only while a conversion runs.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cal_valid <= 1'b0;
      cal_kind <= 2'h0;
    end else begin
      cal_valid <= is_cmd_cal && converting;
      cal_kind <= 2'(cmd_s - adcms_pkg::CMD_SYO_CAL);
    end
  end

  // =====================================================================
  // Checks.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_sleep_enters_pd: assert property (is_cmd_sleep && !is_cmd_reset
    |=> state == adcms_pkg::ST_SLEEP_CMD ##1 !amp_enable && !excitation_enable)
    else $error("sleep command did not power down");
  chk_wake_to_standby: assert property (is_cmd_wake && in_pd |=>
    state == adcms_pkg::ST_STANDBY) else $error("wake did not reach standby");
  chk_pd_drops_write: assert property (wr_evt && in_pd |=>
    $stable(reg_gain) && $stable(reg_rate) && $stable(reg_ref))
    else $error("register write accepted in power-down");
  chk_standby_filter_held: assert property (state == adcms_pkg::ST_STANDBY
    |=> filter_reset && !core_clk_enable) else $error("filter not held in standby");
  chk_amp_off_field: assert property (
    reg_gain[adcms_pkg::AMP_MSB:adcms_pkg::AMP_LSB] == 2'h0 |=> !amp_enable)
    else $error("amplifier on with zero power field");
  chk_ref_off_field: assert property (
    reg_ref[adcms_pkg::REFPWR_MSB:adcms_pkg::REFPWR_LSB] == 2'h0
    |=> !ref_enable && !excitation_enable) else $error("reference on with zero field");
  chk_cal_in_standby: assert property (is_cmd_cal && !converting |=> !cal_valid)
    else $error("calibration decoded outside conversion");
  chk_start_settles: assert property (start_evt && !soft_reset && !is_cmd_sleep
    |=> state == adcms_pkg::ST_SETTLE && timer == $past(settle_load))
    else $error("start did not load settling delay");
  chk_single_ends: assert property (deliver && single_mode && !start_evt && !soft_reset
    && !is_cmd_sleep |=> state == adcms_pkg::ST_STANDBY && !result_ready_n)
    else $error("single-shot did not return to standby");
  chk_stop_finishes: assert property (stop_evt && !single_mode
    && state == adcms_pkg::ST_CONVERT && !last_tick && !start_evt && !soft_reset
    && !is_cmd_sleep |=> state == adcms_pkg::ST_CONVERT)
    else $error("stop aborted running conversion");
  chk_cs_tristate: assert property (cs_sync[1] |=> serial_out_ready_oe_n)
    else $error("output driven with chip select high");
  chk_sinc3_discard: assert property (discard && !start_evt && !soft_reset && !is_cmd_sleep
    |=> result_ready_n == $past(result_ready_n) && state == adcms_pkg::ST_CONVERT)
    else $error("discarded result was flagged");

  cov_single_shot: cover property (deliver && single_mode);
  cov_continuous_stop: cover property (deliver && stop_pending);
  cov_sleep_wake: cover property (in_pd ##[1:1000] is_cmd_wake);
  cov_resync: cover property (converting && is_cmd_stop ##[1:100] is_cmd_start);

endmodule // adcms_ctrl

// ==== include/adcms_pkg.sv ====
// Constants and types shared by the converter mode and serial control logic.
// =====================================================================
package adcms_pkg;

  // =====================================================================
  // Register addresses and fields.
  localparam logic [4:0] ADDR_GAIN = 5'h03;
  localparam logic [4:0] ADDR_RATE = 5'h04;
  localparam logic [4:0] ADDR_REF = 5'h05;
  localparam logic [4:0] ADDR_SETTLE_LAST = 5'h07;
  localparam int SETTLE_MSB = 7;
  localparam int SETTLE_LSB = 5;
  localparam int AMP_MSB = 4;
  localparam int AMP_LSB = 3;
  localparam int MODE_BIT = 5;
  localparam int FILTER_BIT = 4;
  localparam int REFPWR_MSB = 1;
  localparam int REFPWR_LSB = 0;
  localparam logic [7:0] GAIN_RESET = 8'h00;
  localparam logic [7:0] RATE_RESET = 8'h14;
  localparam logic [7:0] REF_RESET = 8'h10;

  // =====================================================================
  // Command opcodes; the control group is matched on its upper seven bits.
  localparam logic [6:0] OP7_WAKE = 7'h01;
  localparam logic [6:0] OP7_SLEEP = 7'h02;
  localparam logic [6:0] OP7_RESET = 7'h03;
  localparam logic [6:0] OP7_START = 7'h04;
  localparam logic [6:0] OP7_STOP = 7'h05;
  localparam logic [7:0] OP_SYO_CAL = 8'h16;
  localparam logic [7:0] OP_SYG_CAL = 8'h17;
  localparam logic [7:0] OP_SFO_CAL = 8'h19;
  localparam logic [2:0] OP_REGISTER_WRITE_CMD_HI = 3'h2;
  localparam logic [2:0] OP_REGISTER_READ_CMD_HI = 3'h1;

  // =====================================================================
  // Timing, in master clock cycles and modulator periods.
  localparam int MOD_PERIOD_CLKS = 16;
  localparam int CONV_MODS_DEFAULT = 64;
  localparam logic [1:0] SINC3_SHOTS = 2'h3;

  typedef enum logic [2:0] {
    CMD_WAKE, CMD_SLEEP, CMD_RESET, CMD_START, CMD_STOP,
    CMD_SYO_CAL, CMD_SYG_CAL, CMD_SFO_CAL
  } adcms_cmd_t;

  typedef enum logic [1:0] {ST_SLEEP_CMD, ST_STANDBY, ST_SETTLE, ST_CONVERT} adcms_state_t;

  typedef enum logic [1:0] {PH_CMD, PH_WCNT, PH_WDATA, PH_RCNT} adcms_phase_t;

endpackage

// ==== bench/adcms_host.sv ====
// Host serial controller model that drives the converter's command port.
module adcms_host (
  // Serial pins towards the converter.
  output logic cs_n,
  output logic sclk,
  output logic din
);
  timeunit 1ns;
  timeprecision 1ps;

  // =====================================================================
  // Idle bus: deselected, clock parked low.
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din = 1'b0;
  end

  // =====================================================================
  // One framed transaction of whole bytes, MSB first, 80 ns link period.
  // Data changes on the rising edge so it is stable at the falling edge.
  task automatic frame(input logic [7:0] q[$]);
    cs_n = 1'b0;
    #40;
    foreach (q[i]) begin
      for (int b = 7; b >= 0; b--) begin
        sclk = 1'b1;
        din = q[i][b];
        #40;
        sclk = 1'b0;
        #40;
      end
    end
    #40;
    cs_n = 1'b1;
    // Between frames the data line idles low so nothing reads as a command.
    din = 1'b0;
    #80;
  endtask
endmodule // adcms_host

// ==== bench/adc_mode_and_serial_control_test.sv ====
// Self-checking testbench for the converter mode and serial control block.
module adc_mode_and_serial_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  // Short modulator and conversion counts keep the run brief.
  localparam int MODC = 2;
  localparam int CONVM = 32;
  localparam int SETTLE = 14 * MODC;
  localparam int CONV = CONVM * MODC;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic trig = 1'b0;
  logic cs_n, sclk, din, sor, oe_n, rdy_n, filt_rst, core_en, amp_en, ref_en, exc_en;
  logic active, cal_v;
  logic [1:0] st, cal_k, last_kind;
  int miscompares = 0;
  int num_checks = 0;
  int cals = 0;

  // =====================================================================
  // Clock, host model and design.
  always #12.5 clk = ~clk;
  adcms_host host (.cs_n(cs_n), .sclk(sclk), .din(din));
  adcms_ctrl #(.MOD_CLKS(MODC), .CONV_MODS(CONVM)) DUT (
    .clk(clk), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk), .din(din),
    .serial_out_ready(sor), .serial_out_ready_oe_n(oe_n),
    .conversion_trigger_pin(trig), .result_ready_n(rdy_n), .op_state(st),
    .filter_reset(filt_rst), .core_clk_enable(core_en), .amp_enable(amp_en),
    .ref_enable(ref_en), .excitation_enable(exc_en), .conv_active(active),
    .cal_valid(cal_v), .cal_kind(cal_k));

  // Calibration requests are one-cycle pulses, so they are counted here.
  always @(posedge clk) if (cal_v === 1'b1) begin
    cals++;
    last_kind = cal_k;
  end

  // =====================================================================
  // Comparison, waiting and closing tasks.
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wait_state(input logic [1:0] exp, input int lim);
    int n;
    n = 0;
    while (st !== exp && n < lim) begin
      @(negedge clk);
      n++;
    end
    check("state", 8'(st), 8'(exp));
  endtask

  // Counts cycles from the end of a start frame to the result flag.
  task automatic run_until_rdy(input int exp);
    int n;
    repeat (3) @(negedge clk);
    n = 3;
    check("state", 8'(st), 8'h02);
    check("clocks", 8'({core_en, filt_rst}), 8'h02);
    check("active", 8'(active), 8'h01);
    while (rdy_n !== 1'b0 && n < exp + 50) begin
      @(negedge clk);
      n++;
    end
    // The start acts some three clocks past its seventh edge, about eight
    // clocks before the frame ends, so the count runs a few short of exp.
    check("result delay", 8'(n >= exp - 7 && n <= exp - 3), 8'h01);
    @(negedge clk);
    check("out ready", 8'(sor), 8'h00);
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // =====================================================================
  // Main sequence; the trigger pin stays low while commands are in use.
  initial begin
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    check("state", 8'(st), 8'h01);
    check("ready", 8'(rdy_n), 8'h01);
    check("clocks", 8'({core_en, filt_rst}), 8'h01);
    check("amp", 8'(amp_en), 8'h00);
    check("ref", 8'({ref_en, exc_en}), 8'h00);
    check("out enable", 8'(oe_n), 8'h01);
    check("out ready", 8'(sor), 8'h01);
    check("active", 8'(active), 8'h00);
    $display("test reset done");
    // Amp on with delay code 0, single-shot low-latency, reference on.
    host.frame('{8'h43, 8'h02, 8'h18, 8'h30, 8'h12});
    repeat (4) @(negedge clk);
    check("amp", 8'(amp_en), 8'h01);
    check("ref", 8'({ref_en, exc_en}), 8'h03);
    host.frame('{8'h08});
    run_until_rdy(SETTLE + CONV);
    wait_state(2'h1, 4);
    host.frame('{8'h44, 8'h00, 8'h20});
    host.frame('{8'h09});
    run_until_rdy(SETTLE + 3 * CONV);
    wait_state(2'h1, 4);
    host.frame('{8'h19});
    repeat (6) @(negedge clk);
    check("idle cal", 8'(cals), 8'h00);
    $display("test single shot done");
    host.frame('{8'h44, 8'h00, 8'h10});
    host.frame('{8'h08});
    run_until_rdy(SETTLE + CONV);
    repeat (3) @(negedge clk);
    check("state", 8'(st), 8'h03);
    fork
      host.frame('{8'h00});
      begin
        #400;
        check("out enable", 8'(oe_n), 8'h00);
      end
    join
    host.frame('{8'h43, 8'h00, 8'h18});
    repeat (2) @(negedge clk);
    check("state", 8'(st), 8'h02);
    wait_state(2'h3, SETTLE + 6);
    host.frame('{8'h16});
    repeat (6) @(negedge clk);
    check("cal count", 8'(cals), 8'h01);
    check("cal kind", 8'(last_kind), 8'h00);
    host.frame('{8'h0a, 8'h08});
    repeat (3) @(negedge clk);
    check("state", 8'(st), 8'h02);
    wait_state(2'h3, SETTLE + 6);
    host.frame('{8'h0b});
    check("state", 8'(st), 8'h03);
    wait_state(2'h1, CONV + 6);
    check("ready", 8'(rdy_n), 8'h00);
    $display("test continuous done");
    host.frame('{8'h05});
    repeat (5) @(negedge clk);
    check("state", 8'(st), 8'h00);
    check("analog", 8'({amp_en, ref_en, exc_en}), 8'h02);
    host.frame('{8'h08});
    host.frame('{8'h45, 8'h00, 8'h10});
    host.frame('{8'h06});
    repeat (5) @(negedge clk);
    check("state", 8'(st), 8'h00);
    host.frame('{8'h03});
    repeat (5) @(negedge clk);
    check("state", 8'(st), 8'h01);
    check("ref", 8'({ref_en, exc_en}), 8'h03);
    trig = 1'b1;
    repeat (6) @(negedge clk);
    check("state", 8'(st), 8'h02);
    wait_state(2'h3, SETTLE + 6);
    trig = 1'b0;
    repeat (3) @(negedge clk);
    check("state", 8'(st), 8'h03);
    wait_state(2'h1, CONV + 6);
    check("ready", 8'(rdy_n), 8'h00);
    host.frame('{8'h07});
    repeat (5) @(negedge clk);
    check("defaults", 8'({amp_en, ref_en, exc_en}), 8'h00);
    check("state", 8'(st), 8'h01);
    $display("test power modes done");
    conclude();
  end

  // A hang is cut short well beyond the expected run of some 40 us.
  initial begin
    #400000;
    miscompares++;
    $display("mismatch watchdog expected finish seen timeout");
    conclude();
  end
endmodule // adc_mode_and_serial_control_test
